// ==== hw/led_sink_cfg.svh ====
`ifndef LED_SINK_CFG_SVH
`define LED_SINK_CFG_SVH

// Channel count and shift register geometry
`define LSC_CH 8
`define LSC_MSB 7
`define LSC_NEXT_MSB 6

// Clock period and documented pulse widths
`define LSC_CLK_NS 10
`define LSC_GATE_MIN_NS 120
`define LSC_LOAD_MIN_NS 200

// Least times rounded up to whole cycles
`define LSC_GATE_MIN_CYC ((`LSC_GATE_MIN_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)
`define LSC_LOAD_MIN_CYC ((`LSC_LOAD_MIN_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)

// Output gate pulse counter
`define LSC_CNT_W 5
`define LSC_CNT_ONE 5'h01
`define LSC_CNT_ZERO 5'h00
`define LSC_CNT_MAX 5'h1f

// Reset values
`define LSC_SR_RST 8'h00
`define LSC_LATCH_RST 8'h00
`define LSC_SINK_RST 8'h00

`endif

// ==== hw/led_sink_pkg.sv ====
`include "led_sink_cfg.svh"

package led_sink_pkg;

    typedef logic [`LSC_MSB:0] chan_vec_t;

    typedef logic [`LSC_CNT_W-1:0] gate_cnt_t;

    typedef enum logic {
        PH_IDLE,
        PH_CHECK
    } phase_t;

    typedef struct packed {
        chan_vec_t open_fault;
        chan_vec_t short_fault;
    } fault_t;

    typedef struct packed {
        logic serial_clk;
        logic serial_in;
        logic latch_load_n;
        logic out_gate_n;
    } pins_t;

    typedef struct packed {
        phase_t phase;
        logic sclk_prev;
        logic load_prev;
        gate_cnt_t gate_cnt;
        chan_vec_t sr;
        chan_vec_t latch;
        chan_vec_t sink;
        logic serial_out;
    } state_t;

endpackage

// ==== hw/channel_check.sv ====
`timescale 1ns/1ps

module channel_check (
    input wire logic i_lit,
    input wire logic i_bit,
    input wire logic i_open_fault,
    input wire logic i_short_fault,
    input wire logic i_open_en,
    input wire logic i_short_en,
    output logic o_bit
);

    always_comb begin
        o_bit = i_bit;
        if (i_open_en && i_lit && i_open_fault) begin
            o_bit = 1'b0;
        end else if (i_short_en && !i_lit && i_short_fault) begin
            o_bit = 1'b1;
        end
    end

endmodule

// ==== hw/led_sink_error_capture.sv ====
`timescale 1ns/1ps
`include "led_sink_cfg.svh"

module led_sink_error_capture
    import led_sink_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_serial_clk,
    input wire logic i_serial_in,
    input wire logic i_latch_load_n,
    input wire logic i_out_gate_n,
    input wire logic [`LSC_MSB:0] i_open_fault,
    input wire logic [`LSC_MSB:0] i_short_fault,
    output logic o_serial_out,
    output logic [`LSC_MSB:0] o_sink_on
);

    localparam gate_cnt_t GATE_MIN = gate_cnt_t'(`LSC_GATE_MIN_CYC);

    localparam state_t ST_RST = '{
        phase: PH_IDLE,
        sclk_prev: 1'b0,
        load_prev: 1'b1,
        gate_cnt: `LSC_CNT_ZERO,
        sr: `LSC_SR_RST,
        latch: `LSC_LATCH_RST,
        sink: `LSC_SINK_RST,
        serial_out: 1'b0
    };

    state_t st_q;
    state_t st_d;
    pins_t pins;
    fault_t fault;
    chan_vec_t checked_sr;
    logic sclk_rise;
    logic load_rise;
    logic gate_long;
    logic open_en;
    logic short_en;

    assign pins = '{
        serial_clk: i_serial_clk,
        serial_in: i_serial_in,
        latch_load_n: i_latch_load_n,
        out_gate_n: i_out_gate_n
    };
    assign fault = '{open_fault: i_open_fault, short_fault: i_short_fault};

    assign sclk_rise = pins.serial_clk && !st_q.sclk_prev;
    assign load_rise = pins.latch_load_n && !st_q.load_prev;
    // Gate pulse strictly longer than the documented minimum
    assign gate_long = st_q.gate_cnt > GATE_MIN;
    assign open_en = (st_q.phase == PH_CHECK) && gate_long && !pins.out_gate_n;
    assign short_en = (st_q.phase == PH_CHECK);

    genvar g;
    generate
        for (g = 0; g < `LSC_CH; g = g + 1) begin : g_chan
            channel_check u_check (
                .i_lit(st_q.latch[g]),
                .i_bit(st_q.sr[g]),
                .i_open_fault(fault.open_fault[g]),
                .i_short_fault(fault.short_fault[g]),
                .i_open_en(open_en),
                .i_short_en(short_en),
                .o_bit(checked_sr[g])
            );
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.sclk_prev = pins.serial_clk;
        st_d.load_prev = pins.latch_load_n;

        // Output gate low time, saturating
        if (pins.out_gate_n) begin
            st_d.gate_cnt = `LSC_CNT_ZERO;
        end else if (st_q.gate_cnt != `LSC_CNT_MAX) begin
            st_d.gate_cnt = st_q.gate_cnt + `LSC_CNT_ONE;
        end

        // Shifting wins over detection and closes the check window
        if (sclk_rise) begin
            st_d.sr = {st_q.sr[`LSC_NEXT_MSB:0], pins.serial_in};
        end else begin
            st_d.sr = checked_sr;
        end
        st_d.serial_out = st_d.sr[`LSC_MSB];

        // Latch is transparent while the load strobe is low
        if (!pins.latch_load_n) begin
            st_d.latch = st_q.sr;
        end

        // Sinks follow the latch, gated by the output enable
        st_d.sink = pins.out_gate_n ? `LSC_SINK_RST : st_q.latch;

        case (st_q.phase)
            PH_IDLE: begin
                if (load_rise && !sclk_rise) begin
                    st_d.phase = PH_CHECK;
                end
            end
            PH_CHECK: begin
                if (sclk_rise || !pins.latch_load_n) begin
                    st_d.phase = PH_IDLE;
                end
            end
            default: begin
                st_d.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_serial_out = st_q.serial_out;
    assign o_sink_on = st_q.sink;

    // Checks

    sequence s_quiet_check;
        (st_q.phase == PH_CHECK) && !sclk_rise && i_latch_load_n;
    endsequence

    sequence s_long_gate;
        !i_out_gate_n && gate_long;
    endsequence

    sequence s_short_gate;
        !(!i_out_gate_n && gate_long);
    endsequence

    sequence s_shift;
        i_serial_clk && !st_q.sclk_prev;
    endsequence

    AST_OPEN_NEEDS_LONG_GATE: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (s_quiet_check and s_short_gate) |=>
            ((st_q.sr ^ $past(st_q.sr)) & $past(st_q.latch)) == `LSC_SR_RST
    ) else $error("Lit channel bit changed without a long gate pulse");

    AST_OPEN_CLEARS_BIT: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (s_quiet_check and s_long_gate) |=>
            (st_q.sr & $past(st_q.latch & i_open_fault)) == `LSC_SR_RST
    ) else $error("Open fault on lit channel did not clear its bit");

    AST_UNLIT_SINK_OFF: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ##1 1'b1 |-> (o_sink_on & ~$past(st_q.latch)) == `LSC_SINK_RST
    ) else $error("Sink on for a channel latched off");

    AST_SHORT_SETS_BIT: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_quiet_check |=>
            (st_q.sr & $past(~st_q.latch & i_short_fault)) ==
            $past(~st_q.latch & i_short_fault)
    ) else $error("Short fault on unlit channel did not set its bit");

    AST_LATCH_UNTOUCHED: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_latch_load_n [*2] |=> $stable(st_q.latch)
    ) else $error("Latch changed while load strobe was high");

    AST_SINK_FOLLOWS_LATCH: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (!i_out_gate_n && i_latch_load_n) [*2] |=> o_sink_on == $past(st_q.latch)
    ) else $error("Sink pattern differs from latched data");

    AST_SERIAL_OUT_SHIFTS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_shift |=> o_serial_out == $past(st_q.sr[`LSC_NEXT_MSB])
    ) else $error("Serial output did not advance on a shift");

    AST_LOAD_ARMS_CHECK: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_latch_load_n && !st_q.load_prev && !sclk_rise) |=>
            st_q.phase == PH_CHECK
    ) else $error("Load release did not open the check window");

    AST_SHIFT_IN: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_shift |=> st_q.sr == {$past(st_q.sr[`LSC_NEXT_MSB:0]), $past(i_serial_in)}
    ) else $error("Shift register did not take the serial input");

    AST_LATCH_COPIES: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_latch_load_n |=> st_q.latch == $past(st_q.sr)
    ) else $error("Latch did not copy the shift register");

    AST_SINK_OFF_GATED: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_out_gate_n |=> o_sink_on == `LSC_SINK_RST
    ) else $error("Sink on while the output gate was released");

    AST_CHECK_KEEPS_SINKS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (s_quiet_check and s_long_gate) |=> o_sink_on == $past(st_q.latch)
    ) else $error("Detection changed the driven output pattern");

    AST_SHIFT_CLOSES_CHECK: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_shift |=> st_q.phase == PH_IDLE
    ) else $error("Check window stayed open across a shift");

endmodule

// ==== dv/display_ctrl.sv ====
`timescale 1ns/1ps

module display_ctrl (
    input wire logic i_clk,
    input wire logic i_serial_out,
    output logic o_serial_clk = 1'b0,
    output logic o_serial_in = 1'b0,
    output logic o_latch_load_n = 1'b1,
    output logic o_out_gate_n = 1'b1
);

    // Shift in new data, MSB first, while capturing the status bits
    task automatic xfer(input logic [7:0] din, output logic [7:0] dout);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_clk);
            o_serial_clk <= 1'b0;
            o_serial_in <= din[i];
            @(posedge i_clk);
            dout[i] = i_serial_out;
            o_serial_clk <= 1'b1;
        end
        @(posedge i_clk);
        o_serial_clk <= 1'b0;
        o_serial_in <= ~din[0];
        @(posedge i_clk);
    endtask

    // Latch load strobe held low past 200ns
    task automatic load();
        @(posedge i_clk);
        o_latch_load_n <= 1'b0;
        repeat (21) @(posedge i_clk);
        o_latch_load_n <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    // Output gate level, set ahead of checking
    task automatic set_gate(input logic n);
        @(posedge i_clk);
        o_out_gate_n <= n;
    endtask

endmodule

// ==== dv/tb_led_sink_error_capture.sv ====
`timescale 1ns/1ps

module tb_led_sink_error_capture;
    import led_sink_pkg::*;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sclk, sin, load_n, gate_n, so;
    chan_vec_t open_f = 8'h00;
    chan_vec_t short_f = 8'h00;
    chan_vec_t sink;
    logic [7:0] msr, mlatch, din, got;
    int bad_count = 0;
    int n_compared = 0;

    led_sink_error_capture dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_serial_clk(sclk), .i_serial_in(sin),
        .i_latch_load_n(load_n), .i_out_gate_n(gate_n), .i_open_fault(open_f),
        .i_short_fault(short_f), .o_serial_out(so), .o_sink_on(sink)
    );

    display_ctrl ctrl (
        .i_clk(i_clk), .i_serial_out(so), .o_serial_clk(sclk), .o_serial_in(sin),
        .o_latch_load_n(load_n), .o_out_gate_n(gate_n)
    );

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        summarize();
    end

    initial begin
        logic [7:0] op, sh;
        void'($urandom(32'h2d2a));
        msr = 8'h00;
        mlatch = 8'h00;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            din = 8'($urandom);
            op = 8'($urandom);
            sh = 8'($urandom);
            ctrl.xfer(din, got);
            chk("status", msr, got);
            msr = din;
            ctrl.set_gate(r[0]);
            ctrl.load();
            mlatch = msr;
            @(posedge i_clk);
            open_f <= op;
            short_f <= sh;
            if (!r[0]) begin
                repeat (20) @(posedge i_clk);
                chk("sink", mlatch, sink);
                msr = (mlatch & ~op) | (~mlatch & sh);
            end else begin
                repeat (3) @(posedge i_clk);
                chk("sink off", 8'h00, sink);
                ctrl.set_gate(1'b0);
                repeat (4) @(posedge i_clk);
                ctrl.set_gate(1'b1);
                repeat (5) @(posedge i_clk);
                msr = mlatch | sh;
            end
            open_f <= 8'h00;
            short_f <= 8'h00;
            $display("round %0d done", r);
        end
        ctrl.xfer(8'h00, got);
        chk("status last", msr, got);
        summarize();
    end

endmodule
